// File: logic/cec_counter.sv
`timescale 1ns/10ps
module cec_counter #(
	parameter int CW = 32
) (
	input  wire logic        ref_clk,
	input  wire logic        srst,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        frame_readout_window,
	input  wire logic        line_period_window,
	input  wire logic        exposure_window,
	input  wire logic        acquisition_window,
	input  wire logic        cc1,
	input  wire logic        external_trigger_input,
	output logic             irq
);
	// a counter wider than the bus word could not be read back whole
	if (CW < 2 || CW > 32) begin : g_cw_check
		$error("CW must lie between 2 and 32");
	end

	// ---------------- source conditioning
	logic [cec_pkg::NUM_SRC-1:0] src_in;
	logic [cec_pkg::NUM_SRC-1:0] src_lvl;
	logic [cec_pkg::NUM_SRC-1:0] src_rise;
	logic [cec_pkg::NUM_SRC-1:0] src_fall;

	// window inputs are driven by the timing generator
	assign src_in[cec_pkg::SRC_FRAME] = frame_readout_window;
	assign src_in[cec_pkg::SRC_LINE]  = line_period_window;
	assign src_in[cec_pkg::SRC_EXPO]  = exposure_window;
	assign src_in[cec_pkg::SRC_ACQ]   = acquisition_window;
	assign src_in[cec_pkg::SRC_CC1]   = cc1;
	assign src_in[cec_pkg::SRC_EXT]   = external_trigger_input;

	// pins and internal windows alike go through the same two stages,
	// so the latency from every source to the counter is equal
	for (genvar i = 0; i < cec_pkg::NUM_SRC; i++) begin : g_src
		cec_edge_sync u_sync (
			.ref_clk(ref_clk),
			.srst   (srst),
			.din    (src_in[i]),
			.level  (src_lvl[i]),
			.rise   (src_rise[i]),
			.fall   (src_fall[i])
		);
	end

	// ---------------- bus slave state
	logic                 aw_have_reg, aw_have_next;
	logic [7:0]           aw_addr_reg, aw_addr_next;
	logic                 w_have_reg,  w_have_next;
	logic [31:0]          w_data_reg,  w_data_next;
	logic [3:0]           w_strb_reg,  w_strb_next;
	logic                 bvalid_reg,  bvalid_next;
	logic [1:0]           bresp_reg,   bresp_next;
	logic                 rvalid_reg,  rvalid_next;
	logic [1:0]           rresp_reg,   rresp_next;
	logic [31:0]          rdata_reg,   rdata_next;
	logic                 do_write;

	// ---------------- configuration state
	logic                        unit_sel_reg,  unit_sel_next;
	cec_pkg::cec_event_sel_t     evt_sel_reg,   evt_sel_next;
	logic                        evt_pol_reg,   evt_pol_next;
	cec_pkg::cec_clear_sel_t     clr_sel_reg,   clr_sel_next;
	cec_pkg::cec_qual_t          clr_qual_reg,  clr_qual_next;
	cec_pkg::cec_start_sel_t     st_sel_reg,    st_sel_next;
	cec_pkg::cec_qual_t          st_qual_reg,   st_qual_next;
	logic [CW-1:0]               limit_reg,     limit_next;
	logic [cec_pkg::IRQ_W-1:0]   irq_stat_reg,  irq_stat_next;
	logic [cec_pkg::IRQ_W-1:0]   irq_mask_reg,  irq_mask_next;
	logic                        sw_clear;

	// ---------------- counter state
	cec_pkg::cec_state_t         state_reg,     state_next;
	logic [CW-1:0]               count_reg,     count_next;
	logic [CW-1:0]               cap_reg,       cap_next;
	logic [cec_pkg::IRQ_W-1:0]   irq_set;
	logic [1:0]                  run_code;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) res[8*b +: 8] = nw[8*b +: 8];
		end
		return res;
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		return a == cec_pkg::OFS_UNIT_SEL  || a == cec_pkg::OFS_EVENT_CFG || a == cec_pkg::OFS_CLEAR_CFG ||
		       a == cec_pkg::OFS_START_CFG || a == cec_pkg::OFS_COMMAND   || a == cec_pkg::OFS_PRESENT   ||
		       a == cec_pkg::OFS_CAPTURED  || a == cec_pkg::OFS_LIMIT     || a == cec_pkg::OFS_RUN_STATE ||
		       a == cec_pkg::OFS_IRQ_STAT  || a == cec_pkg::OFS_IRQ_MASK;
	endfunction

	// edge or level hit of a qualified source
	function automatic logic edge_hit(input cec_pkg::cec_qual_t q, input logic r, input logic f);
		return (q == cec_pkg::Q_RISE && r) || (q == cec_pkg::Q_FALL && f) || (q == cec_pkg::Q_ANY && (r || f));
	endfunction

	function automatic logic level_hit(input cec_pkg::cec_qual_t q, input logic l);
		return (q == cec_pkg::Q_HIGH && l) || (q == cec_pkg::Q_LOW && !l);
	endfunction

	assign s_axi_awready = !aw_have_reg && !bvalid_reg;
	assign s_axi_wready  = !w_have_reg && !bvalid_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rresp   = rresp_reg;
	assign s_axi_rdata   = rdata_reg;
	assign do_write      = aw_have_reg && w_have_reg && !bvalid_reg;

	always_comb begin
		unique case (state_reg)
			cec_pkg::ST_RUN:  run_code = cec_pkg::RUN_ACTIVE;
			cec_pkg::ST_DONE: run_code = cec_pkg::RUN_DONE;
			default:          run_code = cec_pkg::RUN_IDLE;
		endcase
	end

	// ---------------- bus channels
	always_comb begin
		aw_have_next = aw_have_reg;
		aw_addr_next = aw_addr_reg;
		w_have_next  = w_have_reg;
		w_data_next  = w_data_reg;
		w_strb_next  = w_strb_reg;
		bvalid_next  = bvalid_reg;
		bresp_next   = bresp_reg;
		rvalid_next  = rvalid_reg;
		rresp_next   = rresp_reg;
		rdata_next   = rdata_reg;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_have_next = 1'b1;
			aw_addr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_have_next = 1'b1;
			w_data_next = s_axi_wdata;
			w_strb_next = s_axi_wstrb;
		end
		if (do_write) begin
			aw_have_next = 1'b0;
			w_have_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = mapped(aw_addr_reg) ? cec_pkg::RESP_OKAY : cec_pkg::RESP_SLVERR;
		end else if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_next = 1'b1;
			rresp_next  = mapped(s_axi_araddr) ? cec_pkg::RESP_OKAY : cec_pkg::RESP_SLVERR;
			unique case (s_axi_araddr)
				cec_pkg::OFS_UNIT_SEL:  rdata_next = {31'h0, unit_sel_reg};
				cec_pkg::OFS_EVENT_CFG: rdata_next = {27'h0, evt_pol_reg, 1'b0, evt_sel_reg};
				cec_pkg::OFS_CLEAR_CFG: rdata_next = {25'h0, clr_qual_reg, 1'b0, clr_sel_reg};
				cec_pkg::OFS_START_CFG: rdata_next = {25'h0, st_qual_reg, 1'b0, st_sel_reg};
				cec_pkg::OFS_PRESENT:   rdata_next = 32'(count_reg);
				cec_pkg::OFS_CAPTURED:  rdata_next = 32'(cap_reg);
				cec_pkg::OFS_LIMIT:     rdata_next = 32'(limit_reg);
				cec_pkg::OFS_RUN_STATE: rdata_next = {30'h0, run_code};
				cec_pkg::OFS_IRQ_STAT:  rdata_next = 32'(irq_stat_reg);
				cec_pkg::OFS_IRQ_MASK:  rdata_next = 32'(irq_mask_reg);
				default:                rdata_next = 32'h0000_0000;
			endcase
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			aw_have_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_have_reg  <= 1'b0;
			w_data_reg  <= 32'h0000_0000;
			w_strb_reg  <= 4'h0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= cec_pkg::RESP_OKAY;
			rvalid_reg  <= 1'b0;
			rresp_reg   <= cec_pkg::RESP_OKAY;
			rdata_reg   <= 32'h0000_0000;
		end else begin
			aw_have_reg <= aw_have_next;
			aw_addr_reg <= aw_addr_next;
			w_have_reg  <= w_have_next;
			w_data_reg  <= w_data_next;
			w_strb_reg  <= w_strb_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
			rvalid_reg  <= rvalid_next;
			rresp_reg   <= rresp_next;
			rdata_reg   <= rdata_next;
		end
	end

	// ---------------- configuration registers
	always_comb begin
		logic [31:0] wv;
		wv            = 32'h0000_0000;
		unit_sel_next = unit_sel_reg;
		evt_sel_next  = evt_sel_reg;
		evt_pol_next  = evt_pol_reg;
		clr_sel_next  = clr_sel_reg;
		clr_qual_next = clr_qual_reg;
		st_sel_next   = st_sel_reg;
		st_qual_next  = st_qual_reg;
		limit_next    = limit_reg;
		irq_mask_next = irq_mask_reg;
		sw_clear      = 1'b0;
		// set wins over a clear in the same cycle
		irq_stat_next = irq_stat_reg | irq_set;
		if (do_write) begin
			unique case (aw_addr_reg)
				cec_pkg::OFS_EVENT_CFG: begin
					wv           = merge(32'(evt_sel_reg) | (32'(evt_pol_reg) << cec_pkg::POL_BIT), w_data_reg, w_strb_reg);
					evt_sel_next = cec_pkg::cec_event_sel_t'(wv[cec_pkg::SEL_LSB +: cec_pkg::SEL_W]);
					evt_pol_next = wv[cec_pkg::POL_BIT];
				end
				cec_pkg::OFS_CLEAR_CFG: begin
					wv            = merge(32'(clr_sel_reg) | (32'(clr_qual_reg) << cec_pkg::QUAL_LSB), w_data_reg, w_strb_reg);
					clr_sel_next  = cec_pkg::cec_clear_sel_t'(wv[cec_pkg::SEL_LSB +: cec_pkg::SEL_W]);
					clr_qual_next = cec_pkg::cec_qual_t'(wv[cec_pkg::QUAL_LSB +: cec_pkg::QUAL_W]);
				end
				cec_pkg::OFS_START_CFG: begin
					wv           = merge(32'(st_sel_reg) | (32'(st_qual_reg) << cec_pkg::QUAL_LSB), w_data_reg, w_strb_reg);
					st_sel_next  = cec_pkg::cec_start_sel_t'(wv[cec_pkg::SEL_LSB +: cec_pkg::SEL_W]);
					st_qual_next = cec_pkg::cec_qual_t'(wv[cec_pkg::QUAL_LSB +: cec_pkg::QUAL_W]);
				end
				cec_pkg::OFS_UNIT_SEL: begin
					// only unit zero exists; any other choice is refused silently
					if (w_strb_reg[0] && w_data_reg[7:0] == 8'h00) unit_sel_next = 1'b0;
				end
				cec_pkg::OFS_COMMAND:  sw_clear = w_strb_reg[0] && w_data_reg[cec_pkg::CMD_CLEAR];
				cec_pkg::OFS_LIMIT:    limit_next = CW'(merge(32'(limit_reg), w_data_reg, w_strb_reg));
				cec_pkg::OFS_IRQ_STAT: begin
					if (w_strb_reg[0]) irq_stat_next = (irq_stat_reg & ~w_data_reg[cec_pkg::IRQ_W-1:0]) | irq_set;
				end
				cec_pkg::OFS_IRQ_MASK: begin
					if (w_strb_reg[0]) irq_mask_next = w_data_reg[cec_pkg::IRQ_W-1:0];
				end
				default: wv = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			unit_sel_reg <= 1'b0;
			evt_sel_reg  <= cec_pkg::EV_OFF;
			evt_pol_reg  <= 1'b0;
			clr_sel_reg  <= cec_pkg::CL_OFF;
			clr_qual_reg <= cec_pkg::Q_RISE;
			st_sel_reg   <= cec_pkg::SS_OFF;
			st_qual_reg  <= cec_pkg::Q_RISE;
			limit_reg    <= CW'(cec_pkg::RST_LIMIT);
			irq_stat_reg <= cec_pkg::RST_IRQ;
			irq_mask_reg <= cec_pkg::RST_IRQ;
		end else begin
			unit_sel_reg <= unit_sel_next;
			evt_sel_reg  <= evt_sel_next;
			evt_pol_reg  <= evt_pol_next;
			clr_sel_reg  <= clr_sel_next;
			clr_qual_reg <= clr_qual_next;
			st_sel_reg   <= st_sel_next;
			st_qual_reg  <= st_qual_next;
			limit_reg    <= limit_next;
			irq_stat_reg <= irq_stat_next;
			irq_mask_reg <= irq_mask_next;
		end
	end

	assign irq = |(irq_stat_reg & irq_mask_reg);

	// ---------------- counter and run state
	always_comb begin
		int  ei, ci, si;
		logic evt_hit, clr_edge, clr_hold, st_edge, st_hold, st_free, clear_any;
		logic [CW-1:0] inc;
		ei = 0;
		ci = 0;
		si = 0;
		unique case (evt_sel_reg)
			cec_pkg::EV_FRAME: ei = cec_pkg::SRC_FRAME;
			cec_pkg::EV_LINE:  ei = cec_pkg::SRC_LINE;
			cec_pkg::EV_EXPO:  ei = cec_pkg::SRC_EXPO;
			cec_pkg::EV_CC1:   ei = cec_pkg::SRC_CC1;
			default:           ei = cec_pkg::SRC_EXT;
		endcase
		unique case (clr_sel_reg)
			cec_pkg::CL_FRAME: ci = cec_pkg::SRC_FRAME;
			cec_pkg::CL_EXPO:  ci = cec_pkg::SRC_EXPO;
			cec_pkg::CL_ACQ:   ci = cec_pkg::SRC_ACQ;
			default:           ci = cec_pkg::SRC_EXT;
		endcase
		unique case (st_sel_reg)
			cec_pkg::SS_EXPO:  si = cec_pkg::SRC_EXPO;
			cec_pkg::SS_FRAME: si = cec_pkg::SRC_FRAME;
			cec_pkg::SS_CC1:   si = cec_pkg::SRC_CC1;
			default:           si = cec_pkg::SRC_EXT;
		endcase
		// illegal select codes behave as off
		evt_hit   = (evt_sel_reg inside {cec_pkg::EV_FRAME, cec_pkg::EV_LINE, cec_pkg::EV_EXPO,
			cec_pkg::EV_CC1, cec_pkg::EV_EXT}) && (evt_pol_reg ? src_fall[ei] : src_rise[ei]);
		clr_edge  = (clr_sel_reg inside {cec_pkg::CL_FRAME, cec_pkg::CL_EXPO, cec_pkg::CL_ACQ, cec_pkg::CL_EXT})
			&& edge_hit(clr_qual_reg, src_rise[ci], src_fall[ci]);
		clr_hold  = (clr_sel_reg inside {cec_pkg::CL_FRAME, cec_pkg::CL_EXPO, cec_pkg::CL_ACQ, cec_pkg::CL_EXT})
			&& level_hit(clr_qual_reg, src_lvl[ci]);
		st_edge   = (st_sel_reg inside {cec_pkg::SS_EXPO, cec_pkg::SS_FRAME, cec_pkg::SS_CC1, cec_pkg::SS_EXT})
			&& edge_hit(st_qual_reg, src_rise[si], src_fall[si]);
		st_hold   = (st_sel_reg inside {cec_pkg::SS_EXPO, cec_pkg::SS_FRAME, cec_pkg::SS_CC1, cec_pkg::SS_EXT})
			&& level_hit(st_qual_reg, src_lvl[si]);
		st_free   = !(st_sel_reg inside {cec_pkg::SS_EXPO, cec_pkg::SS_FRAME, cec_pkg::SS_CC1, cec_pkg::SS_EXT})
			|| ((st_qual_reg == cec_pkg::Q_HIGH || st_qual_reg == cec_pkg::Q_LOW) && !st_hold);
		clear_any = sw_clear || clr_edge || clr_hold;
		inc        = CW'(count_reg + 1'b1);
		count_next = count_reg;
		cap_next   = cap_reg;
		state_next = state_reg;
		irq_set    = '0;
		unique case (state_reg)
			cec_pkg::ST_IDLE: begin
				if (st_free || st_edge) begin
					state_next = cec_pkg::ST_RUN;
					irq_set[cec_pkg::IRQ_START] = 1'b1;
				end
			end
			cec_pkg::ST_RUN: begin
				if (evt_hit) begin
					count_next = inc;
					if (limit_reg != '0 && inc == limit_reg) begin
						state_next = cec_pkg::ST_DONE;
						irq_set[cec_pkg::IRQ_DONE] = 1'b1;
					end
				end
			end
			cec_pkg::ST_DONE: state_next = cec_pkg::ST_DONE;
			default:          state_next = cec_pkg::ST_IDLE;
		endcase
		if (st_hold) begin
			count_next = '0;
			state_next = cec_pkg::ST_IDLE;
			irq_set[cec_pkg::IRQ_START] = 1'b0;
		end
		// a clear overrides any event of the same cycle
		if (clear_any) begin
			count_next = '0;
			// a held level clear must not overwrite the capture with zero
			if (!clr_hold || count_reg != '0 || sw_clear || clr_edge) cap_next = count_reg;
			irq_set[cec_pkg::IRQ_CLEAR] = 1'b1;
			if (st_hold) state_next = cec_pkg::ST_IDLE;
			else if (sw_clear || st_free) state_next = cec_pkg::ST_RUN;
			else state_next = cec_pkg::ST_IDLE;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state_reg <= cec_pkg::ST_IDLE;
			count_reg <= '0;
			cap_reg   <= '0;
		end else begin
			state_reg <= state_next;
			count_reg <= count_next;
			cap_reg   <= cap_next;
		end
	end
endmodule // cec_counter

// File: pkg/cec_pkg.sv
package cec_pkg;

	localparam int ADDR_W = 8;

	// register byte offsets
	localparam logic [7:0] OFS_UNIT_SEL  = 8'h00;
	localparam logic [7:0] OFS_EVENT_CFG = 8'h04;
	localparam logic [7:0] OFS_CLEAR_CFG = 8'h08;
	localparam logic [7:0] OFS_START_CFG = 8'h0C;
	localparam logic [7:0] OFS_COMMAND   = 8'h10;
	localparam logic [7:0] OFS_PRESENT   = 8'h14;
	localparam logic [7:0] OFS_CAPTURED  = 8'h18;
	localparam logic [7:0] OFS_LIMIT     = 8'h1C;
	localparam logic [7:0] OFS_RUN_STATE = 8'h20;
	localparam logic [7:0] OFS_IRQ_STAT  = 8'h24;
	localparam logic [7:0] OFS_IRQ_MASK  = 8'h28;

	// field positions
	localparam int SEL_LSB    = 0;
	localparam int SEL_W      = 3;
	localparam int POL_BIT    = 4;
	localparam int QUAL_LSB   = 4;
	localparam int QUAL_W     = 3;
	localparam int CMD_CLEAR  = 0;

	// interrupt status bits
	localparam int IRQ_DONE   = 0;
	localparam int IRQ_CLEAR  = 1;
	localparam int IRQ_START  = 2;
	localparam int IRQ_W      = 3;

	// run state codes as read by software
	localparam logic [1:0] RUN_IDLE   = 2'h0;
	localparam logic [1:0] RUN_ACTIVE = 2'h1;
	localparam logic [1:0] RUN_DONE   = 2'h2;

	// source vector indices
	localparam int SRC_FRAME = 0;
	localparam int SRC_LINE  = 1;
	localparam int SRC_EXPO  = 2;
	localparam int SRC_ACQ   = 3;
	localparam int SRC_CC1   = 4;
	localparam int SRC_EXT   = 5;
	localparam int NUM_SRC   = 6;

	localparam int SYNC_STAGES = 2;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// reset values
	localparam logic [2:0]  RST_SEL     = 3'h0;
	localparam logic [31:0] RST_LIMIT   = 32'h0000_0000;
	localparam logic [IRQ_W-1:0] RST_IRQ = 3'h0;

	typedef enum logic [2:0] {
		EV_OFF   = 3'h0,
		EV_FRAME = 3'h1,
		EV_LINE  = 3'h2,
		EV_EXPO  = 3'h3,
		EV_CC1   = 3'h4,
		EV_EXT   = 3'h5
	} cec_event_sel_t;

	typedef enum logic [2:0] {
		CL_OFF   = 3'h0,
		CL_FRAME = 3'h1,
		CL_EXPO  = 3'h2,
		CL_ACQ   = 3'h3,
		CL_EXT   = 3'h4
	} cec_clear_sel_t;

	typedef enum logic [2:0] {
		SS_OFF   = 3'h0,
		SS_EXPO  = 3'h1,
		SS_FRAME = 3'h2,
		SS_CC1   = 3'h3,
		SS_EXT   = 3'h4
	} cec_start_sel_t;

	typedef enum logic [2:0] {
		Q_RISE = 3'h0,
		Q_FALL = 3'h1,
		Q_ANY  = 3'h2,
		Q_HIGH = 3'h3,
		Q_LOW  = 3'h4
	} cec_qual_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_RUN  = 3'b010,
		ST_DONE = 3'b100
	} cec_state_t;

endpackage

// File: logic/cec_edge_sync.sv
`timescale 1ns/10ps
module cec_edge_sync (
	input  wire logic ref_clk,
	input  wire logic srst,
	input  wire logic din,
	output logic      level,
	output logic      rise,
	output logic      fall
);
	logic [cec_pkg::SYNC_STAGES-1:0] sync_reg;
	logic [cec_pkg::SYNC_STAGES-1:0] sync_next;
	logic                            prev_reg;
	logic                            prev_next;

	// first stage is read only by the second one
	always_comb begin
		sync_next = {sync_reg[cec_pkg::SYNC_STAGES-2:0], din};
		prev_next = sync_reg[cec_pkg::SYNC_STAGES-1];
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sync_reg <= '0;
			prev_reg <= 1'b0;
		end else begin
			sync_reg <= sync_next;
			prev_reg <= prev_next;
		end
	end

	assign level = sync_reg[cec_pkg::SYNC_STAGES-1];
	assign rise  = level & ~prev_reg;
	assign fall  = ~level & prev_reg;
endmodule // cec_edge_sync

// File: testbench/cec_counter_asserts.sv
`timescale 1ns/10ps
module cec_counter_asserts #(
	parameter int CW = 32
) (
	input wire logic        ref_clk,
	input wire logic        srst,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        irq
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (srst);
	sequence rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	rd_answer_a: assert property (rd_take |=> s_axi_rvalid)
		else $error("read not answered next cycle");
	rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");
	rd_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address accepted while answer pending");
	rd_single_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
	// the write acts one edge after both halves are taken, bvalid shows after that edge
	wr_answer_a: assert property (wr_take |=> ##1 s_axi_bvalid)
		else $error("write not answered within two cycles");
	wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before taken");
	wr_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	// reset must quiet the bus even when it lands mid-transfer
	rst_quiet_a: assert property (@(posedge ref_clk) disable iff (1'b0) srst |=> !s_axi_bvalid && !s_axi_rvalid && !irq)
		else $error("outputs active after reset");
endmodule // cec_counter_asserts

bind cec_counter cec_counter_asserts #(.CW(CW)) i_cec_counter_asserts (.ref_clk(ref_clk), .srst(srst),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .irq(irq));

// File: testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
	logic        ref_clk, srst, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp, lr;
	logic        awready, wready, bvalid, arready, rvalid, irq;
	logic [5:0]  src;
	int          error_cnt, num_checks, seed, cnt, n;
	int          emap[5] = '{0, 1, 2, 4, 5};

	cec_counter i_cec_counter (.ref_clk(ref_clk), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .frame_readout_window(src[0]), .line_period_window(src[1]),
		.exposure_window(src[2]), .acquisition_window(src[3]), .cc1(src[4]),
		.external_trigger_input(src[5]), .irq(irq));

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask

	// readies sampled at the falling edge, so the release never races the design's flops
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = cec_pkg::RESP_OKAY);
		logic da, dw, na, nw;
		da = 0;
		dw = 0;
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(da && dw)) begin
			@(negedge ref_clk);
			na = awready && !da;
			nw = wready && !dw;
			@(posedge ref_clk);
			if (na) begin
				da = 1;
				awvalid <= 1'b0;
			end
			if (nw) begin
				dw = 1;
				wvalid <= 1'b0;
			end
		end
		do @(negedge ref_clk); while (bvalid !== 1'b1);
		chk("bresp", bresp, er);
		@(posedge ref_clk);
		bready <= 1'b0;
	endtask

	task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(negedge ref_clk); while (arready !== 1'b1);
		@(posedge ref_clk);
		arvalid <= 1'b0;
		do @(negedge ref_clk); while (rvalid !== 1'b1);
		lr = rresp;
		chk(nm, rdata, e);
		@(posedge ref_clk);
		rready <= 1'b0;
	endtask

	// six cycles covers the two sync flops, the edge register and the count update
	task pin(input int i, input logic v);
		@(posedge ref_clk);
		src[i] <= v;
		repeat (6) @(posedge ref_clk);
	endtask

	task report_and_stop;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		#(25 * 30000);
		error_cnt++;
		report_and_stop;
	end

	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wdata, src} = 54'h0;
		seed = 29576;
		srst = 1'b1;
		repeat (16) @(posedge ref_clk);
		srst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rdc("state", cec_pkg::OFS_RUN_STATE, cec_pkg::RUN_ACTIVE);
		wr(cec_pkg::OFS_UNIT_SEL, 32'h1);
		rdc("unit", cec_pkg::OFS_UNIT_SEL, 32'h0);
		wr(8'h3C, 32'h5, cec_pkg::RESP_SLVERR);
		rdc("hole", 8'h40, 32'h0);
		chk("rresp", lr, cec_pkg::RESP_SLVERR);
		for (int e = 0; e < 5; e++) begin
			for (int p = 0; p < 2; p++) begin
				wr(cec_pkg::OFS_EVENT_CFG, (p << 4) | (e + 1));
				wr(cec_pkg::OFS_COMMAND, 32'h1);
				cnt = 0;
				n = 1 + ($random(seed) & 3);
				repeat (n) begin
					pin(emap[e], 1'b1);
					cnt += (p == 0);
					rdc("half", cec_pkg::OFS_PRESENT, cnt);
					pin(emap[e], 1'b0);
					cnt += (p == 1);
				end
				rdc("count", cec_pkg::OFS_PRESENT, cnt);
			end
		end
		wr(cec_pkg::OFS_EVENT_CFG, 32'h1);
		wr(cec_pkg::OFS_COMMAND, 32'h1);
		rdc("sw", cec_pkg::OFS_PRESENT, 32'h0);
		rdc("cap", cec_pkg::OFS_CAPTURED, cnt);
		wr(cec_pkg::OFS_EVENT_CFG, 32'h0);
		pin(0, 1'b1);
		pin(0, 1'b0);
		rdc("off", cec_pkg::OFS_PRESENT, 32'h0);
		wr(cec_pkg::OFS_EVENT_CFG, 32'h1);
		wr(cec_pkg::OFS_CLEAR_CFG, 32'h24);
		for (int t = 0; t < 2; t++) begin
			n = 1 + ($random(seed) & 3);
			repeat (n) begin
				pin(0, 1'b1);
				pin(0, 1'b0);
			end
			pin(5, t == 0);
			rdc("edge", cec_pkg::OFS_PRESENT, 32'h0);
			rdc("cap", cec_pkg::OFS_CAPTURED, n);
		end
		wr(cec_pkg::OFS_CLEAR_CFG, 32'h33);
		pin(3, 1'b1);
		repeat (2) begin
			pin(0, 1'b1);
			pin(0, 1'b0);
		end
		rdc("level", cec_pkg::OFS_PRESENT, 32'h0);
		pin(3, 1'b0);
		wr(cec_pkg::OFS_CLEAR_CFG, 32'h0);
		// a software clear resumes counting, so a low-level hold parks the run in idle
		wr(cec_pkg::OFS_START_CFG, 32'h41);
		wr(cec_pkg::OFS_START_CFG, 32'h1);
		rdc("wait", cec_pkg::OFS_RUN_STATE, cec_pkg::RUN_IDLE);
		pin(0, 1'b1);
		pin(0, 1'b0);
		rdc("idle", cec_pkg::OFS_PRESENT, 32'h0);
		pin(2, 1'b1);
		rdc("go", cec_pkg::OFS_RUN_STATE, cec_pkg::RUN_ACTIVE);
		wr(cec_pkg::OFS_START_CFG, 32'h31);
		pin(0, 1'b1);
		pin(0, 1'b0);
		rdc("hold", cec_pkg::OFS_PRESENT, 32'h0);
		pin(2, 1'b0);
		pin(0, 1'b1);
		rdc("free", cec_pkg::OFS_PRESENT, 32'h1);
		pin(0, 1'b0);
		wr(cec_pkg::OFS_START_CFG, 32'h0);
		wr(cec_pkg::OFS_LIMIT, 32'h3);
		wr(cec_pkg::OFS_COMMAND, 32'h1);
		wr(cec_pkg::OFS_IRQ_STAT, 32'h7);
		repeat (5) begin
			pin(0, 1'b1);
			pin(0, 1'b0);
		end
		rdc("limit", cec_pkg::OFS_PRESENT, 32'h3);
		rdc("done", cec_pkg::OFS_RUN_STATE, cec_pkg::RUN_DONE);
		rdc("stat", cec_pkg::OFS_IRQ_STAT, 32'h1);
		chk("masked", irq, 1'b0);
		wr(cec_pkg::OFS_IRQ_MASK, 32'h1);
		@(negedge ref_clk);
		chk("irq", irq, 1'b1);
		wr(cec_pkg::OFS_IRQ_STAT, 32'h1);
		@(negedge ref_clk);
		chk("w1c", irq, 1'b0);
		// reset after the run is done: count, status and interrupt must start over
		@(posedge ref_clk);
		srst <= 1'b1;
		@(posedge ref_clk);
		srst <= 1'b0;
		rdc("rst_cnt", cec_pkg::OFS_PRESENT, 32'h0);
		rdc("rst_stat", cec_pkg::OFS_IRQ_STAT, 32'h4);
		chk("rst_irq", irq, 1'b0);
		report_and_stop;
	end
endmodule // testbench
